// file: tsf_pkg.sv
package tsf_pkg;
   // register indices on the internal register port
   localparam logic [7:0] ADDR_WARN_STATUS = 8'h41;
   localparam logic [7:0] ADDR_TRIP_STATUS = 8'h42;
   localparam logic [7:0] ADDR_FAULT_STATUS = 8'h43;
   localparam logic [7:0] ADDR_CONFIG1 = 8'h50;
   // field positions
   localparam int WARN_LOCAL_BIT = 6;
   localparam int TRIP_CH1_BIT = 0;
   localparam int TRIP_CH4_BIT = 3;
   localparam int CFG_BETA_BIT = 2;
   localparam int CFG_RCANCEL_BIT = 3;
   localparam int FAULT_UNUSED_LO = 5;
   localparam int FAULT_UNUSED_HI = 6;
   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONFIG1_RESET = 8'h0C;
   // channel numbering: 0 local, 1..4 remote
   localparam int NUM_CH = 5;
   localparam logic [2:0] CH_LOCAL = 3'h0;
   localparam logic [2:0] CH_REMOTE1 = 3'h1;
   localparam logic [2:0] CH_REMOTE4 = 3'h4;
   // hysteresis in degrees
   localparam logic [8:0] HYST_DEG = 9'h004;
   // conversion extension under cancellation
   localparam int RCANCEL_EXTRA_MS = 125;
   localparam int CLK_MHZ = 200;
   localparam int RCANCEL_EXTRA_CYC = RCANCEL_EXTRA_MS * 1000 * CLK_MHZ;
endpackage : tsf_pkg

// file: tsf_hyst_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module tsf_hyst_cmp (
   input wire logic [7:0] temp,
   input wire logic [7:0] limit,
   input wire logic over_now,
   output logic over_next
);
   // set above limit, release only below limit minus hysteresis
   always_comb begin
      if (temp > limit) begin
         over_next = 1'b1;
      end else if (({1'b0, temp} + tsf_pkg::HYST_DEG) < {1'b0, limit}) begin
         over_next = 1'b0;
      end else begin
         over_next = over_now;
      end
   end
endmodule : tsf_hyst_cmp
`default_nettype wire

// file: tsf_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tsf_status_flags #(
   parameter int RCANCEL_EXTRA = tsf_pkg::RCANCEL_EXTRA_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic ara_ack,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [2:0] conv_chan,
   input wire logic [7:0] conv_temp,
   input wire logic [7:0] warn_limit,
   input wire logic [7:0] trip_limit,
   input wire logic conv_fault,
   output logic ch1_extend,
   output logic res_cancel_en,
   output logic beta_comp_en,
   output logic alert_out,
   output logic alert_oe_n,
   output logic thermal_trip_out,
   output logic trip_oe_n
);
   logic [7:0] warn_flag;
   logic [7:0] trip_flag;
   logic [7:0] fault_flag;
   logic [4:1] diode_fault;
   logic [7:0] config1;
   logic [4:0] warn_over;
   logic [1:0] trip_over;
   logic alert_act;
   logic por_done;
   logic [31:0] ext_cnt;
   logic warn_cur;
   logic trip_cur;
   logic next_warn_over;
   logic next_trip_over;
   logic chan_ok;
   logic trip_chan;
   logic trip_idx;
   logic [2:0] warn_bit;
   logic rd_warn;
   logic rd_trip;

   // decode of the converted channel
   assign chan_ok = (conv_chan < 3'(tsf_pkg::NUM_CH));
   assign trip_chan = (conv_chan == tsf_pkg::CH_REMOTE1) || (conv_chan == tsf_pkg::CH_REMOTE4);
   assign trip_idx = (conv_chan == tsf_pkg::CH_REMOTE4);
   assign warn_cur = chan_ok ? warn_over[conv_chan] : 1'b0;
   assign trip_cur = trip_over[trip_idx];
   assign warn_bit = (conv_chan == tsf_pkg::CH_LOCAL) ?
      3'(tsf_pkg::WARN_LOCAL_BIT) : 3'(conv_chan - 3'h1);
   assign rd_warn = reg_rd && (reg_addr == tsf_pkg::ADDR_WARN_STATUS);
   assign rd_trip = reg_rd && (reg_addr == tsf_pkg::ADDR_TRIP_STATUS);

   // hysteresis comparators for the channel now finishing
   tsf_hyst_cmp u_warn_cmp (
      .temp(conv_temp),
      .limit(warn_limit),
      .over_now(warn_cur),
      .over_next(next_warn_over)
   );
   tsf_hyst_cmp u_trip_cmp (
      .temp(conv_temp),
      .limit(trip_limit),
      .over_now(trip_cur),
      .over_next(next_trip_over)
   );

   // per-channel over-limit conditions, updated at end of conversion
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         warn_over <= 5'h00;
         trip_over <= 2'h0;
      end else if (conv_done && chan_ok) begin
         warn_over[conv_chan] <= next_warn_over;
         if (trip_chan) begin
            trip_over[trip_idx] <= next_trip_over;
         end
      end
   end

   // warning status: set at conversion end, cleared by read, set wins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         warn_flag <= tsf_pkg::STATUS_RESET;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (conv_done && chan_ok && next_warn_over && (warn_bit == 3'(i))) begin
               warn_flag[i] <= 1'b1;
            end else if (rd_warn) begin
               warn_flag[i] <= 1'b0;
            end
         end
      end
   end

   // trip status: only channels 1 and 4, cleared only by its read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         trip_flag <= tsf_pkg::STATUS_RESET;
      end else begin
         if (conv_done && trip_chan && next_trip_over) begin
            if (trip_idx) begin
               trip_flag[tsf_pkg::TRIP_CH4_BIT] <= 1'b1;
            end else begin
               trip_flag[tsf_pkg::TRIP_CH1_BIT] <= 1'b1;
            end
            if (rd_trip) begin
               trip_flag[trip_idx ? tsf_pkg::TRIP_CH1_BIT : tsf_pkg::TRIP_CH4_BIT] <= 1'b0;
            end
         end else if (rd_trip) begin
            trip_flag <= tsf_pkg::STATUS_RESET;
         end
      end
   end

   // diode fault flags follow the detector at own-channel conversion end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         diode_fault <= 4'h0;
      end else if (conv_done && chan_ok && (conv_chan != tsf_pkg::CH_LOCAL)) begin
         diode_fault[conv_chan] <= conv_fault;
      end
   end

   // unused fault bits rise to 1 after the first edge past reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         por_done <= 1'b0;
      end else begin
         por_done <= 1'b1;
      end
   end
   // fault status image: one driver for the whole byte, reserved bits 0
   always_comb begin
      fault_flag = 8'h00;
      fault_flag[4:1] = diode_fault;
      fault_flag[tsf_pkg::FAULT_UNUSED_LO] = por_done;
      fault_flag[tsf_pkg::FAULT_UNUSED_HI] = por_done;
   end

   // configuration 1: cancellation and beta compensation controls
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         config1 <= tsf_pkg::CONFIG1_RESET;
      end else if (reg_wr && (reg_addr == tsf_pkg::ADDR_CONFIG1)) begin
         config1[tsf_pkg::CFG_RCANCEL_BIT] <= reg_wdata[tsf_pkg::CFG_RCANCEL_BIT];
         config1[tsf_pkg::CFG_BETA_BIT] <= reg_wdata[tsf_pkg::CFG_BETA_BIT];
      end
   end
   assign res_cancel_en = config1[tsf_pkg::CFG_RCANCEL_BIT];
   assign beta_comp_en = config1[tsf_pkg::CFG_BETA_BIT];

   // channel 1 conversion stretch while cancellation is on
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ext_cnt <= 32'h0000_0000;
      end else if (conv_start && (conv_chan == tsf_pkg::CH_REMOTE1) && res_cancel_en) begin
         ext_cnt <= 32'(RCANCEL_EXTRA);
      end else if (ext_cnt != 32'h0000_0000) begin
         ext_cnt <= ext_cnt - 32'h0000_0001;
      end
   end
   assign ch1_extend = (ext_cnt != 32'h0000_0000);

   // alert latch: set at conversion end, released by read or response
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         alert_act <= 1'b0;
      end else if (conv_done && chan_ok && next_warn_over) begin
         alert_act <= 1'b1;
      end else if (rd_warn || ara_ack) begin
         alert_act <= 1'b0;
      end
   end
   assign alert_out = 1'b0;
   assign alert_oe_n = !alert_act;
   assign thermal_trip_out = 1'b0;
   assign trip_oe_n = !(trip_over[0] || trip_over[1]);

   // read data; writes to status registers have no effect
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == tsf_pkg::ADDR_WARN_STATUS) begin
            reg_rdata <= warn_flag;
         end else if (reg_addr == tsf_pkg::ADDR_TRIP_STATUS) begin
            reg_rdata <= trip_flag;
         end else if (reg_addr == tsf_pkg::ADDR_FAULT_STATUS) begin
            reg_rdata <= fault_flag;
         end else if (reg_addr == tsf_pkg::ADDR_CONFIG1) begin
            reg_rdata <= config1;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   sequence s_warn_read;
      rd_warn && !conv_done;
   endsequence
   sequence s_trip_read;
      rd_trip && !conv_done;
   endsequence

   a_warn_set_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
      conv_done && chan_ok && next_warn_over |=> warn_flag[$past(warn_bit)])
      else $error("warning flag not set after over-limit conversion");
   a_warn_read_clr: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_warn_read |=> (warn_flag == 8'h00) && !alert_act)
      else $error("warning read did not clear flags and alert");
   a_trip_read_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_trip_read |=> (trip_flag == 8'h00) && $stable(trip_oe_n))
      else $error("trip read changed trip output or left flags");
   a_status_no_drift: assert property (@(posedge ref_clk) disable iff (!resetn)
      por_done && !conv_done && !reg_rd |=>
      $stable(warn_flag) && $stable(trip_flag) && $stable(fault_flag))
      else $error("status changed outside conversion end");
   a_fault_unused_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
      por_done && reg_rd && (reg_addr == tsf_pkg::ADDR_FAULT_STATUS) |=>
      reg_rdata[6:5] == 2'b11)
      else $error("unused fault bits not reading one");
   a_cfg_reset_on: assert property (@(posedge ref_clk) disable iff (!resetn)
      !por_done |-> beta_comp_en && res_cancel_en)
      else $error("compensation not enabled after reset");
   a_ext_start: assert property (@(posedge ref_clk) disable iff (!resetn)
      conv_start && (conv_chan == tsf_pkg::CH_REMOTE1) && res_cancel_en |=> ch1_extend)
      else $error("channel 1 conversion not stretched");
   a_hyst_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      conv_done && chan_ok && warn_cur && (conv_temp <= warn_limit) &&
      (({1'b0, conv_temp} + tsf_pkg::HYST_DEG) >= {1'b0, warn_limit}) |=>
      warn_over[$past(conv_chan)])
      else $error("over-limit released inside hysteresis band");
   a_trip_flag_pos: assert property (@(posedge ref_clk) disable iff (!resetn)
      trip_flag[7:4] == 4'h0 && trip_flag[2:1] == 2'h0)
      else $error("reserved trip bit set");
endmodule : tsf_status_flags
`default_nettype wire

// file: tsf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsf_host_model #(
   parameter bit DIODE_SENSOR = 1'b0
) (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata
);
   // idle bus after power-up
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // one completed read byte; idle address scrambled
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
   // one write byte; stale data scrambled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // beta compensation only with cancellation, never for a diode sensor
      if (a == tsf_pkg::ADDR_CONFIG1 && ((v[2] && !v[3]) || DIODE_SENSOR)) v[2] = 1'b0;
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask : wr
endmodule : tsf_host_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk = 1'b0, resetn = 1'b0, conv_start = 1'b0, conv_done = 1'b0;
   logic conv_fault = 1'b0, ara_ack = 1'b0;
   logic [2:0] conv_chan = 3'h0;
   logic [7:0] conv_temp = 8'h00, warn_limit = 8'h00, trip_limit = 8'h00;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_rd, reg_wr, ch1_extend, res_cancel_en, beta_comp_en;
   logic alert_out, alert_oe_n, thermal_trip_out, trip_oe_n;
   logic [7:0] exp_q[$];
   int miscompares = 0, n_checks = 0, seed = 99, cnt;
   // clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   tsf_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata));
   tsf_status_flags #(.RCANCEL_EXTRA(10)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .ara_ack(ara_ack), .conv_start(conv_start),
      .conv_done(conv_done), .conv_chan(conv_chan), .conv_temp(conv_temp),
      .warn_limit(warn_limit), .trip_limit(trip_limit), .conv_fault(conv_fault),
      .ch1_extend(ch1_extend), .res_cancel_en(res_cancel_en), .beta_comp_en(beta_comp_en),
      .alert_out(alert_out), .alert_oe_n(alert_oe_n), .thermal_trip_out(thermal_trip_out),
      .trip_oe_n(trip_oe_n));
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // note the expected byte, then read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd
   // one conversion result
   task automatic conv(input logic [2:0] c, input logic [7:0] t, input logic [7:0] w,
      input logic [7:0] p, input logic f);
      @(negedge ref_clk);
      conv_chan = c;
      conv_temp = t;
      warn_limit = w;
      trip_limit = p;
      conv_fault = f;
      conv_done = 1'b1;
      @(negedge ref_clk);
      conv_done = 1'b0;
      conv_temp = ~t;
   endtask : conv
   // start channel 1 and count stretched cycles
   task automatic stretch(input int e);
      @(negedge ref_clk);
      conv_chan = 3'h1;
      conv_start = 1'b1;
      cnt = 0;
      repeat (30) begin
         @(negedge ref_clk);
         conv_start = 1'b0;
         cnt += int'(ch1_extend === 1'b1);
      end
      chk("ch1_extend", 8'(cnt), 8'(e));
   endtask : stretch
   // read data watcher
   always @(posedge ref_clk) begin
      if (reg_rd === 1'b1) begin
         @(negedge ref_clk);
         if (exp_q.size() == 0) chk("queue", 8'h00, 8'hFF);
         else chk("reg_rdata", reg_rdata, exp_q.pop_front());
      end
   end
   // hang guard
   initial begin
      #100us;
      miscompares++;
      test_done();
   end
   // main sequence
   initial begin
      repeat (6) @(negedge ref_clk);
      resetn = 1'b1;
      chk("oe", 8'({alert_out, thermal_trip_out, ch1_extend, alert_oe_n, trip_oe_n,
         beta_comp_en, res_cancel_en}), 8'h0F);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h00);
      rd(tsf_pkg::ADDR_TRIP_STATUS, 8'h00);
      rd(tsf_pkg::ADDR_FAULT_STATUS, 8'h60);
      rd(8'h7E, 8'h00);
      rd(tsf_pkg::ADDR_CONFIG1, tsf_pkg::CONFIG1_RESET);
      for (int c = 0; c < 5; c++) begin
         conv(3'(c), 8'h65 + 8'($unsigned($random(seed)) % 32), 8'h64, 8'hFF, 1'b0);
      end
      chk("alert_oe_n", 8'(alert_oe_n), 8'h00);
      host.wr(tsf_pkg::ADDR_WARN_STATUS, 8'hFF);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h4F);
      chk("alert_oe_n", 8'(alert_oe_n), 8'h01);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h00);
      conv(3'h2, 8'h62, 8'h64, 8'hFF, 1'b0);
      chk("alert_oe_n", 8'(alert_oe_n), 8'h00);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h02);
      conv(3'h3, 8'h70, 8'h64, 8'hFF, 1'b0);
      @(negedge ref_clk);
      ara_ack = 1'b1;
      @(negedge ref_clk);
      ara_ack = 1'b0;
      chk("alert_oe_n", 8'(alert_oe_n), 8'h01);
      for (int c = 1; c < 5; c++) conv(3'(c), 8'h64, 8'hFF, 8'h5A, 1'b0);
      chk("trip_oe_n", 8'(trip_oe_n), 8'h00);
      rd(tsf_pkg::ADDR_TRIP_STATUS, 8'h09);
      rd(tsf_pkg::ADDR_TRIP_STATUS, 8'h00);
      chk("trip_oe_n", 8'(trip_oe_n), 8'h00);
      conv(3'h1, 8'h56, 8'hFF, 8'h5A, 1'b0);
      conv(3'h4, 8'h56, 8'hFF, 8'h5A, 1'b0);
      chk("trip_oe_n", 8'(trip_oe_n), 8'h00);
      conv(3'h1, 8'h55, 8'hFF, 8'h5A, 1'b0);
      conv(3'h4, 8'h55, 8'hFF, 8'h5A, 1'b0);
      chk("trip_oe_n", 8'(trip_oe_n), 8'h01);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h04);
      conv(3'h1, 8'h32, 8'hFF, 8'hFF, 1'b1);
      conv(3'h4, 8'h32, 8'hFF, 8'hFF, 1'b1);
      conv(3'h0, 8'h32, 8'hFF, 8'hFF, 1'b1);
      conv(3'h5, 8'hC8, 8'h64, 8'h5A, 1'b1);
      chk("alert_oe_n", 8'(alert_oe_n), 8'h01);
      rd(tsf_pkg::ADDR_FAULT_STATUS, 8'h72);
      rd(tsf_pkg::ADDR_WARN_STATUS, 8'h00);
      conv(3'h1, 8'h32, 8'hFF, 8'hFF, 1'b0);
      rd(tsf_pkg::ADDR_FAULT_STATUS, 8'h70);
      stretch(10);
      host.wr(tsf_pkg::ADDR_CONFIG1, 8'hFF);
      rd(tsf_pkg::ADDR_CONFIG1, 8'h0C);
      host.wr(tsf_pkg::ADDR_CONFIG1, 8'h08);
      chk("cfg", 8'({res_cancel_en, beta_comp_en}), 8'h02);
      host.wr(tsf_pkg::ADDR_CONFIG1, 8'h00);
      chk("res_cancel_en", 8'(res_cancel_en), 8'h00);
      stretch(0);
      test_done();
   end
endmodule : tb
`default_nettype wire
